// *** design/wdwp_watchdog.sv ***
// Window watchdog with sticky dual-register group write protection
`timescale 1ns/1ps
`include "wdwp_consts.svh"

// Behaviour
// - Mode 00 idle; mode 01 escalates interrupt, reset, then power-down.
// - Mode 10: first expiry resets, next expiry powers down.
// - Mode 11: every expiry powers down at once.
// - Sleep bit 0 stops watchdog in sleep; 1 keeps it running.
// - Wait 1 to 8 full periods before the first closed window.
// - Start delay on reset release, mode write, or sleep exit.
// - Power-down copies shutdown mode into the forced shutdown field.
// - Closed code steps 1 ms, then 2 ms, then 4 ms.
// - Open window uses the same code; 00h 1 ms, FFh 864 ms.
// - Eight-bit key register resets to zero; host writes it to service.
// - Configuration and windows load from memory; locked when group protected.
// - A group is protected only when set in both protection registers.
// - Protection bits reset to zero and cannot be cleared by writes.
// - Self test on leaving sequence 5 or 6 clears both protections.
// - Bit 6..0 select groups; bit 7 reserved; protected writes ignored.
// - Read-only target address from memory in bits 6 to 0.
module wdwp_watchdog #(
  parameter int TICK_CYCLES = `WDWP_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic nvmValid,
  input wire logic [7:0] nvmConfig,
  input wire logic [7:0] nvmClosed,
  input wire logic [7:0] nvmOpen,
  input wire logic [6:0] storedTargetAddress,
  input wire wdwp_pkg::wdwp_req_t busReq,
  input wire logic sleepPin,
  input wire logic resetOutputLowRelease,
  input wire logic bistClear,
  output wdwp_pkg::wdwp_rsp_t busRsp,
  output logic [6:0] groupLocked
);
  import wdwp_pkg::*;

  wdwp_state_t s_q;
  wdwp_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Window code to milliseconds
  // piecewise decode
  function automatic logic [10:0] codeToMs(input logic [7:0] code);
    logic [10:0] c;
    c = {3'b000, code};

    if (code < 8'h20)
      codeToMs = c + 11'h001;
    else if (code < 8'h40)
      codeToMs = 11'(2 * (c - 11'h01F)) + 11'h020;
    else
    // same code, 40h is 100 ms
      codeToMs = 11'(4 * (c - 11'h03F)) + 11'h060;
  endfunction

  // Period is closed plus open; 11 bits hold the 1728 ms worst case
  function automatic logic [10:0] periodMs(input logic [7:0] cl, input logic [7:0] op);
    periodMs = codeToMs(cl) + codeToMs(op);
  endfunction

  // A write that lands on the key register
  function automatic logic isKeyWrite(input wdwp_req_t req);
    isKeyWrite = req.write && (req.addr == `WDWP_ADDR_KEY);
  endfunction

  // Mode field of a configuration value
  function automatic logic [1:0] modeOf(input logic [7:0] cfg);
    modeOf = cfg[`WDWP_MODE_HI:`WDWP_MODE_LO];
  endfunction

  // Protection bits only set; reserved bit stays low
  function automatic logic [7:0] stickySet(input logic [7:0] old, input logic [7:0] wdata);
    stickySet = old | (wdata & `WDWP_PROT_MASK);
  endfunction

  // Read value of one register; unmapped reads zero
  function automatic logic [7:0] readValue(input wdwp_state_t s, input logic [7:0] addr);
    unique case (addr)
      `WDWP_ADDR_CFG: readValue = s.cfg;
      `WDWP_ADDR_CLOSE: readValue = s.closeCode;
      `WDWP_ADDR_OPEN: readValue = s.openCode;
      `WDWP_ADDR_KEY: readValue = s.key;
      `WDWP_ADDR_PROT_A: readValue = s.protA;
      `WDWP_ADDR_PROT_B: readValue = s.protB;
      `WDWP_ADDR_TADDR: readValue = s.taddr;
      default: readValue = 8'h00;
    endcase
  endfunction

  // Escalation step on one expiry: {interrupt, reset, power-down, next stage}
  function automatic logic [4:0] escalate(input logic [1:0] sel, input logic [1:0] stg);
    logic irq;
    logic rstOut;
    logic pd;
    logic [1:0] next;

    irq = 1'b0;
    rstOut = 1'b0;
    pd = 1'b0;
    next = stg;

    unique case (sel)
      2'b01:
      begin
        irq = (stg == 2'd0);
        rstOut = (stg == 2'd1);
        pd = (stg >= 2'd2);
        // Stays at power-down after the third expiry
        next = (stg >= 2'd2) ? 2'd2 : stg + 2'd1;
      end

      2'b10:
      begin
        rstOut = (stg == 2'd0);
        pd = (stg != 2'd0);
        next = 2'd1;
      end

      2'b11: pd = 1'b1;
      default: next = 2'd0;
    endcase

    escalate = {irq, rstOut, pd, next};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic groupLockWdt;
  logic wrHit;
  logic running;
  logic sleeping;
  logic tickDone;
  logic msDone;

  // Expiry and restart conditions
  logic [1:0] mode;
  logic keyWrite;
  logic keyEarly;
  logic keyInOpen;
  logic openMissed;
  logic expiry;
  logic sleepExit;
  logic restart;

  always_comb
  begin
    s_d = s_q;
    s_d.rsp.irqPulse = 1'b0;
    s_d.rsp.resetPulse = 1'b0;
    s_d.rsp.powerDownPulse = 1'b0;

    groupLocked = s_q.protA[6:0] & s_q.protB[6:0];
    groupLockWdt = groupLocked[`WDWP_LOCK_WDT];
    wrHit = busReq.write;

    // Pin crosses two flops; the second and its one-cycle-late copy are looked at
    s_d.sleepQ1 = sleepPin;
    s_d.sleepQ2 = s_q.sleepQ1;
    s_d.sleepPrev = s_q.sleepQ2;
    sleeping = s_q.sleepQ2;
    mode = modeOf(s_q.cfg);

    running = (mode != 2'b00) &&
      (!sleeping || s_q.cfg[`WDWP_SLEEP_BIT]);
    tickDone = (s_q.tick == 15'(TICK_CYCLES - 1));
    msDone = tickDone && (s_q.msLeft == 11'h001);
    keyWrite = isKeyWrite(busReq);

    // key too early, key in time, or key missing
    keyEarly = running && (s_q.phase == WDWP_CLOSED) && keyWrite;
    keyInOpen = running && (s_q.phase == WDWP_OPENW) && keyWrite;
    // A key on the last open cycle is still late
    openMissed = running && (s_q.phase == WDWP_OPENW) && msDone;
    expiry = keyEarly || openMissed;

    // sleep exit restarts only when the watchdog stopped in sleep
    sleepExit = s_q.sleepPrev && !s_q.sleepQ2 && !s_q.cfg[`WDWP_SLEEP_BIT];
    restart = resetOutputLowRelease || sleepExit;

    if (!s_q.loaded && nvmValid)
    begin
      s_d.cfg = nvmConfig;
      s_d.closeCode = nvmClosed;
      s_d.openCode = nvmOpen;
      s_d.loaded = 1'b1;
    end

    s_d.taddr = {1'b0, storedTargetAddress};

    // Millisecond time base runs only while the watchdog does
    if (!running)
      s_d.phase = WDWP_OFF;
    else
    begin
      s_d.tick = tickDone ? 15'h0000 : s_q.tick + 15'h0001;
      if (tickDone)
        s_d.msLeft = s_q.msLeft - 11'h001;
    end

    unique case (s_q.phase)
      WDWP_OFF:
        if (running)
        begin
          // delay of 1 to 8 periods
          s_d.phase = WDWP_DELAY;
          s_d.periodsLeft = s_q.cfg[`WDWP_DLY_HI:`WDWP_DLY_LO];
          s_d.tick = 15'h0000;
          s_d.msLeft = periodMs(s_q.closeCode, s_q.openCode);
        end

      WDWP_DELAY:
        if (running && msDone)
        begin
          s_d.msLeft = periodMs(s_q.closeCode, s_q.openCode);
          if (s_q.periodsLeft == 3'h0)
          begin
            s_d.phase = WDWP_CLOSED;
            s_d.msLeft = codeToMs(s_q.closeCode);
          end
          else
            s_d.periodsLeft = s_q.periodsLeft - 3'h1;
        end

      WDWP_CLOSED:
        if (running && msDone)
        begin
          s_d.phase = WDWP_OPENW;
          s_d.msLeft = codeToMs(s_q.openCode);
        end

      WDWP_OPENW:
        if (running && msDone)
        begin
          s_d.phase = WDWP_CLOSED;
          s_d.msLeft = codeToMs(s_q.closeCode);
        end
    endcase

    // key in the open window or an expiry starts a new period
    if (keyInOpen || expiry)
    begin
      s_d.phase = WDWP_CLOSED;
      s_d.tick = 15'h0000;
      s_d.msLeft = codeToMs(s_q.closeCode);
    end

    if (expiry)
      {s_d.rsp.irqPulse, s_d.rsp.resetPulse, s_d.rsp.powerDownPulse, s_d.stage} =
        escalate(mode, s_q.stage);

    if (s_d.rsp.powerDownPulse)
      s_d.rsp.forcedShutdownField = s_q.cfg[`WDWP_WATCHDOG_SHUTDOWN_MODE_HI:`WDWP_WATCHDOG_SHUTDOWN_MODE_LO];

    // reset release and sleep exit restart delay
    if (restart)
    begin
      s_d.phase = WDWP_OFF;
      s_d.stage = 2'd0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Register writes
    if (wrHit)
    begin
      unique case (busReq.addr)
        `WDWP_ADDR_CFG:
          if (!groupLockWdt)
          begin
            s_d.cfg = busReq.wdata;
            s_d.phase = WDWP_OFF;
            s_d.stage = 2'd0;
          end

        `WDWP_ADDR_CLOSE:
          if (!groupLockWdt)
            s_d.closeCode = busReq.wdata;

        `WDWP_ADDR_OPEN:
          if (!groupLockWdt)
            s_d.openCode = busReq.wdata;

        `WDWP_ADDR_KEY:
          s_d.key = busReq.wdata;

        `WDWP_ADDR_PROT_A:
          s_d.protA = stickySet(s_q.protA, busReq.wdata);

        `WDWP_ADDR_PROT_B:
          s_d.protB = stickySet(s_q.protB, busReq.wdata);

        // Address register and unmapped offsets take no write
        default:
          s_d.key = s_q.key;
      endcase
    end

    // self test clears protection, winning over a protect write
    if (bistClear)
    begin
      s_d.protA = `WDWP_PROT_RESET;
      s_d.protB = `WDWP_PROT_RESET;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Read data, registered
    s_d.rsp.rdata = readValue(s_q, busReq.addr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      // Zero first, then the registers with a defined power-on value
      s_q <= '0;
      s_q.key <= `WDWP_KEY_RESET;
      s_q.protA <= `WDWP_PROT_RESET;
      s_q.protB <= `WDWP_PROT_RESET;
      s_q.phase <= WDWP_OFF;
    end
    else
      s_q <= s_d;
  end

  assign busRsp = s_q.rsp;
endmodule

// *** inc/wdwp_consts.svh ***
// Offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDWP_CONSTS_SVH
`define WDWP_CONSTS_SVH
`define WDWP_ADDR_CFG 8'h80
`define WDWP_ADDR_CLOSE 8'h81
`define WDWP_ADDR_OPEN 8'h82
`define WDWP_ADDR_KEY 8'h83
`define WDWP_ADDR_PROT_A 8'hF0
`define WDWP_ADDR_PROT_B 8'hF1
`define WDWP_ADDR_TADDR 8'hF9
`define WDWP_MODE_HI 7
`define WDWP_MODE_LO 6
`define WDWP_SLEEP_BIT 5
`define WDWP_DLY_HI 4
`define WDWP_DLY_LO 2
`define WDWP_WATCHDOG_SHUTDOWN_MODE_HI 1
`define WDWP_WATCHDOG_SHUTDOWN_MODE_LO 0
`define WDWP_LOCK_WDT 2
`define WDWP_KEY_RESET 8'h00
`define WDWP_PROT_RESET 8'h00
`define WDWP_PROT_MASK 8'h7F
`define WDWP_CLOCK_HZ 20000000
`define WDWP_TICK_MS 1
`define WDWP_TICK_CYCLES ((`WDWP_CLOCK_HZ / 1000) * `WDWP_TICK_MS)
`endif

// *** inc/wdwp_pkg.sv ***
// Types of the watchdog and write-protection block
package wdwp_pkg;
  typedef enum logic [1:0] {WDWP_OFF, WDWP_DELAY, WDWP_CLOSED, WDWP_OPENW} wdwp_phase_t;
  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdwp_req_t;
  typedef struct packed {
    logic [7:0] rdata;
    logic [1:0] forcedShutdownField;
    logic irqPulse;
    logic resetPulse;
    logic powerDownPulse;
  } wdwp_rsp_t;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] closeCode;
    logic [7:0] openCode;
    logic [7:0] key;
    logic [7:0] protA;
    logic [7:0] protB;
    logic [7:0] taddr;
    logic loaded;
    wdwp_phase_t phase;
    logic [14:0] tick;
    logic [10:0] msLeft;
    logic [2:0] periodsLeft;
    logic [1:0] stage;
    logic sleepQ1;
    logic sleepQ2;
    logic sleepPrev;
    wdwp_rsp_t rsp;
  } wdwp_state_t;
endpackage

// *** test/tb_top.sv ***
// Self-checking bench of the watchdog block
`timescale 1ns/1ps
module tb_top;
  import wdwp_pkg::*;
  logic clock = 1'b0, rst = 1'b1, nvmValid = 1'b0, sleepPin = 1'b0, bistClear = 1'b0;
  logic resetRelease = 1'b0;
  logic [7:0] v;
  logic [2:0] p;
  logic [7:0] ra [8] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hF0, 8'hF1, 8'hF9, 8'h84};
  logic [7:0] re [8] = '{8'h00, 8'h20, 8'h40, 8'h00, 8'h00, 8'h00, 8'h2A, 8'h00};
  logic [7:0] md [3] = '{8'h41, 8'h81, 8'hC1};
  logic [2:0] ex [9] = '{3'h4, 3'h2, 3'h1, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1};
  int mismatches = 0, samples_checked = 0;
  time t0;
  wdwp_req_t busReq;
  wdwp_rsp_t busRsp;
  logic [6:0] groupLocked;
  ////////////////////////////////////////
  initial forever #25 clock = ~clock;
  wdwp_host u_host (.clock(clock), .busRsp(busRsp), .busReq(busReq));
  // Short tick keeps each millisecond at four cycles
  wdwp_watchdog #(.TICK_CYCLES(4)) u_dut (.clock(clock), .rst(rst), .nvmValid(nvmValid),
    .nvmConfig(8'h00), .nvmClosed(8'h20), .nvmOpen(8'h40), .storedTargetAddress(7'h2A),
    .busReq(busReq), .sleepPin(sleepPin), .resetOutputLowRelease(resetRelease),
    .bistClear(bistClear), .busRsp(busRsp), .groupLocked(groupLocked));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, v);
    chk("rdata", e, v);
  endtask
  // Waits for any expiry action, none if quiet
  task automatic wp(input int n, input logic [2:0] e);
    p = 3'h0;
    for (int i = 0; i < n && p == 3'h0; i++)
    begin
      @(negedge clock);
      p = {busRsp.irqPulse, busRsp.resetPulse, busRsp.powerDownPulse};
    end
    chk("expiry", 8'(e), 8'(p));
  endtask
  task automatic tchk(input int lo, input int hi);
    chk("interval", 8'h01, 8'((($time - t0) / 50) inside {[lo:hi]}));
    t0 = $time;
  endtask
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    #(12000 * 50);
    mismatches++;
    end_of_test();
  end
  initial
  begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    nvmValid = 1'b1;
    foreach (ra[i]) rchk(ra[i], re[i]);
    t0 = $time;
    u_host.wr(8'h80, 8'hC2);
    wp(1200, 3'h1);
    tchk(1071, 1077);
    wp(600, 3'h1);
    tchk(535, 538);
    chk("shutdown", 8'h02, 8'(busRsp.forcedShutdownField));
    u_host.wr(8'h83, 8'h5A);
    p = {busRsp.irqPulse, busRsp.resetPulse, busRsp.powerDownPulse};
    chk("expiry", 8'h01, 8'(p));
    rchk(8'h83, 8'h5A);
    u_host.wr(8'h81, 8'h00);
    u_host.wr(8'h82, 8'h00);
    foreach (md[i])
    begin
      u_host.wr(8'h80, md[i]);
      for (int k = 0; k < 3; k++) wp(100, ex[3 * i + k]);
    end
    u_host.wr(8'h80, 8'h00);
    wp(100, 3'h0);
    sleepPin = 1'b1;
    u_host.wr(8'h80, 8'hC0);
    wp(100, 3'h0);
    u_host.wr(8'h80, 8'hE0);
    wp(100, 3'h1);
    sleepPin = 1'b0;
    u_host.wr(8'h82, 8'h05);
    u_host.wr(8'h80, 8'hC0);
    wp(200, 3'h1);
    repeat (12) @(negedge clock);
    u_host.wr(8'h83, 8'h11);
    wp(20, 3'h0);
    wp(40, 3'h1);
    @(negedge clock) resetRelease = 1'b1;
    @(negedge clock) resetRelease = 1'b0;
    wp(40, 3'h0);
    wp(40, 3'h1);
    u_host.wr(8'hF0, 8'h04);
    u_host.wr(8'h80, 8'h00);
    rchk(8'h80, 8'h00);
    u_host.wr(8'hF1, 8'h84);
    chk("locked", 8'h04, 8'(groupLocked));
    rchk(8'hF1, 8'h04);
    u_host.wr(8'h80, 8'hC0);
    rchk(8'h80, 8'h00);
    u_host.wr(8'hF0, 8'h00);
    rchk(8'hF0, 8'h04);
    u_host.wr(8'hF9, 8'h00);
    rchk(8'hF9, 8'h2A);
    @(negedge clock) bistClear = 1'b1;
    @(negedge clock) bistClear = 1'b0;
    rchk(8'hF0, 8'h00);
    rchk(8'hF1, 8'h00);
    end_of_test();
  end
endmodule

// *** test/wdwp_host.sv ***
// Host model issuing register accesses
`timescale 1ns/1ps
module wdwp_host (
  input wire logic clock,
  input wire wdwp_pkg::wdwp_rsp_t busRsp,
  output wdwp_pkg::wdwp_req_t busReq
);
  import wdwp_pkg::*;
  initial busReq = '0;
  ////////////////////////////////////////
  // Host writes one register for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock) busReq = '{1'b1, a, d};
    // Data inverted once released
    @(negedge clock) busReq = '{1'b0, a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock) busReq = '{1'b0, a, 8'h00};
    @(negedge clock) d = busRsp.rdata;
  endtask
endmodule

// *** test/wdwp_monitor.sv ***
// Port checker of the watchdog block
`timescale 1ns/1ps
module wdwp_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire wdwp_pkg::wdwp_req_t busReq,
  input wire logic [6:0] storedTargetAddress,
  input wire logic bistClear,
  input wire wdwp_pkg::wdwp_rsp_t busRsp,
  input wire logic [6:0] groupLocked
);
  import wdwp_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Past of reset guards the first edges
  property p_sticky;
    !$past(rst) && |($past(groupLocked) & ~groupLocked) |-> $past(bistClear);
  endproperty
  a_sticky: assert property (p_sticky) else $error("lock bit cleared");
  property p_set;
    |(groupLocked & ~$past(groupLocked)) |-> $past(busReq.write) && $past(busReq.addr[7:1]) == 7'h78;
  endproperty
  a_set: assert property (p_set) else $error("lock set without write");
  property p_bist; bistClear |=> groupLocked == 7'h00; endproperty
  a_bist: assert property (p_bist) else $error("self test kept locks");
  property p_fsd;
    !$past(rst) && $changed(busRsp.forcedShutdownField) |-> busRsp.powerDownPulse;
  endproperty
  a_fsd: assert property (p_fsd) else $error("shutdown field moved");
  property p_excl; $onehot0({busRsp.irqPulse, busRsp.resetPulse, busRsp.powerDownPulse}); endproperty
  a_excl: assert property (p_excl) else $error("two expiry actions");
  property p_pd; busRsp.powerDownPulse |=> !busRsp.powerDownPulse; endproperty
  a_pd: assert property (p_pd) else $error("power-down not a pulse");
  property p_taddr;
    $past(busReq.addr) == 8'hF9 && !$past(rst, 2) |-> busRsp.rdata == {1'b0, $past(storedTargetAddress, 2)};
  endproperty
  a_taddr: assert property (p_taddr) else $error("target address wrong");
  property p_key;
    busReq.write && busReq.addr == 8'h83 ##1 busReq.addr == 8'h83 |=> busRsp.rdata == $past(busReq.wdata, 2);
  endproperty
  a_key: assert property (p_key) else $error("key readback wrong");
  property p_lock;
    groupLocked[2] && busReq.write && busReq.addr == 8'h80 ##1 busReq.addr == 8'h80 |=> $stable(busRsp.rdata);
  endproperty
  a_lock: assert property (p_lock) else $error("locked config changed");
  c_pd: cover property (busRsp.powerDownPulse);
  c_irq: cover property (busRsp.irqPulse);
  c_lock: cover property (bistClear && groupLocked[2]);
endmodule
bind wdwp_watchdog wdwp_monitor u_mon (.clock(clock), .rst(rst), .busReq(busReq),
  .storedTargetAddress(storedTargetAddress), .bistClear(bistClear), .busRsp(busRsp),
  .groupLocked(groupLocked));
